// *** src/armed_trigger_operation_csrs.sv ***
// Per-processor armed/triggered operation CSR bank
//
// Contract
// - Armed write to operation CSR issues it, sets triggered, clears armed unless triggered was already set.
// - Unarmed cache management write issues nothing, flags unchanged.
// - Four operation contexts, each applied only to its own processor.
// - Fetch triggered bit 53, reset clear, set by coherent short read when armed.
// - Fetch arm bits 54:55, reset clear, cleared by first short read.
// - Short read becomes semaphore operation only when targeting coherent space.
// - Fetch arm codes: 0 off, 1 increment, 2 decrement, 3 clear.
// - Triggered bit 62 set by hardware on armed operation, cleared by software.
// - Armed bit 63 set by software, gates all armed operation CSRs.
// - Operation access maps flags 00-00, 01-10, 10-00 (10-10 for cache writes), 11-11.
// - TLB invalidate maps flags 00-00, 01-00, 10-00, 11-11.
// - Four operation address registers, bits 24:63, readable.
// - Address register loads on own write and four operation writes.
// - Low node-zero addresses are remapped to the local node.
// - Flush global, prefetch read, prefetch write addresses per processor.
// - Store data carries 40-bit line address, copied into address register.
`timescale 1ns/1ps
module armed_trigger_operation_csrs
    import op_csr_pkg::*;
#(
    parameter int PROC_COUNT = PROC_MAX
) (
    input  wire logic                         clk_in,
    input  wire logic                         nrst_in,
    input  wire op_csr_pkg::csr_req_t         csr_req_in,
    input  wire op_csr_pkg::short_read_t      short_read_in,
    input  wire logic                         tlb_inval_in,
    input  wire logic [op_csr_pkg::NODE_W-1:0] local_node_in,
    input  wire logic [1:0]                   local_remap_size_select_in,
    output op_csr_pkg::csr_rsp_t              csr_rsp_out,
    output op_csr_pkg::op_issue_t             op_issue_out,
    output op_csr_pkg::op_issue_t             sem_issue_out
);
    import op_csr_pkg::*;

    if (PROC_COUNT < 1 || PROC_COUNT > PROC_MAX) begin : g_bad_count
        $error("PROC_COUNT must be 1 to 4");
    end

    logic              proc_ok;
    logic              is_op;
    logic              is_cache;
    logic              loads_addr;
    op_kind_t          kind;
    logic [ADDR_W-1:0] op_addr_raw;
    logic [ADDR_W-1:0] op_addr_map;
    logic [ADDR_W-1:0] sr_addr_map;
    logic              sr_ok;

    logic [ADDR_W-1:0]     addr_reg [PROC_COUNT];
    logic [PROC_COUNT-1:0] armed;
    logic [PROC_COUNT-1:0] trig;
    logic [PROC_COUNT-1:0] ftrig;
    logic [FARM_W-1:0]     farm [PROC_COUNT];
    logic [PROC_COUNT-1:0] fire;
    logic [PROC_COUNT-1:0] sem_fire;

    // Request decode; processor index comes from the transaction source
    assign proc_ok = csr_req_in.valid && (32'(csr_req_in.proc) < PROC_COUNT);
    assign sr_ok   = short_read_in.valid && (32'(short_read_in.proc) < PROC_COUNT);

    always_comb begin
        is_op      = 1'b1;
        is_cache   = 1'b0;
        loads_addr = 1'b0;
        kind       = OP_NONE;
        case (csr_req_in.sel)
            SEL_FETCH_INC: kind = OP_FETCH_INC;
            SEL_FETCH_DEC: kind = OP_FETCH_DEC;
            SEL_FETCH_CLR: kind = OP_FETCH_CLR;
            SEL_NC_READ:   kind = OP_NC_READ;
            SEL_NC_WRITE:  kind = OP_NC_WRITE;
            SEL_COH_INC: begin
                kind       = OP_COH_INC;
                loads_addr = csr_req_in.write;
            end
            SEL_FLUSH: begin
                kind       = OP_FLUSH;
                is_cache   = 1'b1;
                loads_addr = csr_req_in.write;
            end
            SEL_PREF_RD: begin
                kind       = OP_PREF_RD;
                is_cache   = 1'b1;
                loads_addr = csr_req_in.write;
            end
            SEL_PREF_WR: begin
                kind       = OP_PREF_WR;
                is_cache   = 1'b1;
                loads_addr = csr_req_in.write;
            end
            SEL_ADDRESS: begin
                is_op      = 1'b0;
                loads_addr = csr_req_in.write;
            end
            default: is_op = 1'b0;
        endcase
        // Cache operations only act on a store
        if (is_cache && !csr_req_in.write) begin
            is_op = 1'b0;
        end
    end

    // Stores to the coherent increment and cache operation CSRs take their address from the store data
    always_comb begin
        if (loads_addr) begin
            op_addr_raw = csr_req_in.wdata[ADDR_W-1:0];
        end else begin
            op_addr_raw = addr_reg[csr_req_in.proc];
        end
    end

    local_node_remap u_op_remap (
        .addr_in                    (op_addr_raw),
        .local_node_in              (local_node_in),
        .local_remap_size_select_in (local_remap_size_select_in),
        .addr_out                   (op_addr_map)
    );

    local_node_remap u_sr_remap (
        .addr_in                    (short_read_in.addr),
        .local_node_in              (local_node_in),
        .local_remap_size_select_in (local_remap_size_select_in),
        .addr_out                   (sr_addr_map)
    );

    // One context per processor
    for (genvar p = 0; p < PROC_COUNT; p++) begin : g_slot
        logic mine;
        logic sr_mine;
        assign mine    = proc_ok && (32'(csr_req_in.proc) == p);
        assign sr_mine = sr_ok && (32'(short_read_in.proc) == p);

        op_context_slot u_slot (
            .clk_in       (clk_in),
            .nrst_in      (nrst_in),
            .ctx_wr_in    (mine && csr_req_in.write && (csr_req_in.sel == SEL_CONTEXT)),
            .wdata_in     (csr_req_in.wdata),
            .op_access_in (mine && is_op),
            .cache_op_in  (is_cache),
            .tlb_inval_in (tlb_inval_in),
            .sread_in     (sr_mine),
            .sread_coh_in (short_read_in.coherent),
            .armed_out    (armed[p]),
            .trig_out     (trig[p]),
            .farm_out     (farm[p]),
            .ftrig_out    (ftrig[p]),
            .fire_out     (fire[p]),
            .sem_fire_out (sem_fire[p])
        );

        // Operation address register
        always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                addr_reg[p] <= '0;
            end else if (mine && loads_addr) begin
                addr_reg[p] <= csr_req_in.wdata[ADDR_W-1:0];
            end
        end
    end

    // Register read path
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            csr_rsp_out <= '0;
        end else begin
            csr_rsp_out.valid <= csr_req_in.valid && !csr_req_in.write;
            csr_rsp_out.rdata <= '0;
            if (proc_ok && !csr_req_in.write) begin
                if (csr_req_in.sel == SEL_CONTEXT) begin
                    csr_rsp_out.rdata[ARMED_IDX]             <= armed[csr_req_in.proc];
                    csr_rsp_out.rdata[TRIG_IDX]              <= trig[csr_req_in.proc];
                    csr_rsp_out.rdata[FARM_LSB +: FARM_W]    <= farm[csr_req_in.proc];
                    csr_rsp_out.rdata[FTRIG_IDX]             <= ftrig[csr_req_in.proc];
                end else if (csr_req_in.sel == SEL_ADDRESS) begin
                    csr_rsp_out.rdata[OPADDR_W-1:0] <= addr_reg[csr_req_in.proc];
                end
            end
        end
    end

    // Operation issue toward the rest of the system
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            op_issue_out <= '0;
        end else begin
            op_issue_out.valid <= |fire;
            if (|fire) begin
                op_issue_out.kind  <= kind;
                op_issue_out.proc  <= csr_req_in.proc;
                op_issue_out.addr  <= op_addr_map;
                op_issue_out.wdata <= csr_req_in.wdata;
            end
        end
    end

    // Short read translated into a non-coherent semaphore operation
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sem_issue_out <= '0;
        end else begin
            sem_issue_out.valid <= |sem_fire;
            if (|sem_fire) begin
                case (farm[short_read_in.proc])
                    FARM_INC: sem_issue_out.kind <= OP_FETCH_INC;
                    FARM_DEC: sem_issue_out.kind <= OP_FETCH_DEC;
                    FARM_CLR: sem_issue_out.kind <= OP_FETCH_CLR;
                    default:  sem_issue_out.kind <= OP_NONE;
                endcase
                sem_issue_out.proc  <= short_read_in.proc;
                sem_issue_out.addr  <= sr_addr_map;
                sem_issue_out.wdata <= '0;
            end
        end
    end
endmodule

// *** src/local_node_remap.sv ***
// Forces low node-zero addresses onto the local node
`timescale 1ns/1ps
module local_node_remap
    import op_csr_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [NODE_W-1:0] local_node_in,
    input  wire logic [1:0]        local_remap_size_select_in,
    output logic      [ADDR_W-1:0] addr_out
);
    logic [ADDR_W-1:0] mask;
    logic              low;

    always_comb begin
        mask = '0;
        for (int i = 0; i < ADDR_W; i++) begin
            if (i <= ZERO_MSB) begin
                case (local_remap_size_select_in)
                    2'h0:    mask[i] = (i >= ZERO_LSB_32M);
                    2'h1:    mask[i] = (i >= ZERO_LSB_64M);
                    default: mask[i] = (i >= ZERO_LSB_128M);
                endcase
            end
        end
        low = ((addr_in & mask) == '0) && (addr_in[NODE_LSB +: NODE_W] == '0);
        addr_out = addr_in;
        if (low) begin
            addr_out[NODE_LSB +: NODE_W] = local_node_in;
        end
    end
endmodule

// *** src/op_context_slot.sv ***
// One processor's armed/triggered operation context
`timescale 1ns/1ps
module op_context_slot
    import op_csr_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic              ctx_wr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              op_access_in,
    input  wire logic              cache_op_in,
    input  wire logic              tlb_inval_in,
    input  wire logic              sread_in,
    input  wire logic              sread_coh_in,
    output logic                   armed_out,
    output logic                   trig_out,
    output logic [FARM_W-1:0]      farm_out,
    output logic                   ftrig_out,
    output logic                   fire_out,
    output logic                   sem_fire_out
);
    logic armed;
    logic trig;
    logic [FARM_W-1:0] farm;
    logic ftrig;

    assign fire_out     = op_access_in && armed;
    assign sem_fire_out = sread_in && sread_coh_in && (farm != FARM_OFF);
    assign armed_out    = armed;
    assign trig_out     = trig;
    assign farm_out     = farm;
    assign ftrig_out    = ftrig;

    // Armed and triggered transitions
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            armed <= 1'b0;
            trig  <= 1'b0;
        end else if (ctx_wr_in) begin
            armed <= wdata_in[ARMED_IDX];
            trig  <= wdata_in[TRIG_IDX];
        end else if (op_access_in) begin
            if (cache_op_in && !armed) begin
                armed <= armed;
                trig  <= trig;
            end else begin
                trig  <= armed;
                armed <= armed && trig;
            end
        end else if (tlb_inval_in) begin
            armed <= armed && trig;
            trig  <= armed && trig;
        end
    end

    // Short read fetch arm field; TLB purges leave it alone
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            farm <= FARM_OFF;
        end else if (ctx_wr_in) begin
            farm <= wdata_in[FARM_LSB +: FARM_W];
        end else if (sread_in) begin
            farm <= FARM_OFF;
        end
    end

    // Fetch triggered: hardware set wins over a software clear
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ftrig <= 1'b0;
        end else if (sem_fire_out) begin
            ftrig <= 1'b1;
        end else if (ctx_wr_in) begin
            ftrig <= wdata_in[FTRIG_IDX];
        end
    end
endmodule

// *** src/op_csr_pkg.sv ***
// Shared constants, encodings and carrier types for the operation CSR bank
package op_csr_pkg;
    localparam int DATA_W    = 64;
    localparam int ADDR_W    = 40;
    localparam int PROC_W    = 2;
    localparam int PROC_MAX  = 4;
    // Bits are printed MSB-first (bit 0 is the MSB); vector index = 63 - printed bit
    localparam int ARMED_IDX = 0;   // Printed bit 63
    localparam int TRIG_IDX  = 1;   // Printed bit 62
    localparam int FARM_LSB  = 8;   // Printed bits 54:55
    localparam int FARM_W    = 2;
    localparam int FTRIG_IDX = 10;  // Printed bit 53
    localparam int OPADDR_W  = 40;  // Printed bits 24:63
    // Address layout used by the local node remap
    localparam int NODE_LSB  = 34;
    localparam int NODE_W    = 2;
    localparam int ZERO_MSB  = 33;
    localparam int ZERO_LSB_32M  = 25;
    localparam int ZERO_LSB_64M  = 26;
    localparam int ZERO_LSB_128M = 27;

    typedef enum logic [3:0] {
        SEL_CONTEXT   = 4'h0,
        SEL_ADDRESS   = 4'h1,
        SEL_FETCH_INC = 4'h2,
        SEL_FETCH_DEC = 4'h3,
        SEL_FETCH_CLR = 4'h4,
        SEL_NC_READ   = 4'h5,
        SEL_NC_WRITE  = 4'h6,
        SEL_COH_INC   = 4'h7,
        SEL_FLUSH     = 4'h8,
        SEL_PREF_RD   = 4'h9,
        SEL_PREF_WR   = 4'hA
    } sel_t;

    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_FETCH_INC = 4'h1,
        OP_FETCH_DEC = 4'h2,
        OP_FETCH_CLR = 4'h3,
        OP_NC_READ   = 4'h4,
        OP_NC_WRITE  = 4'h5,
        OP_COH_INC   = 4'h6,
        OP_FLUSH     = 4'h7,
        OP_PREF_RD   = 4'h8,
        OP_PREF_WR   = 4'h9
    } op_kind_t;

    localparam logic [1:0] FARM_OFF = 2'h0;
    localparam logic [1:0] FARM_INC = 2'h1;
    localparam logic [1:0] FARM_DEC = 2'h2;
    localparam logic [1:0] FARM_CLR = 2'h3;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [PROC_W-1:0] proc;
        sel_t              sel;
        logic [DATA_W-1:0] wdata;
    } csr_req_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] rdata;
    } csr_rsp_t;

    typedef struct packed {
        logic              valid;
        logic [PROC_W-1:0] proc;
        logic              coherent;
        logic [ADDR_W-1:0] addr;
    } short_read_t;

    typedef struct packed {
        logic              valid;
        op_kind_t          kind;
        logic [PROC_W-1:0] proc;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } op_issue_t;
endpackage

// *** tb/armed_trigger_operation_csrs_assertions.sv ***
// Port-level assertion checker for the operation CSR bank
`timescale 1ns/1ps
module armed_trigger_operation_csrs_assertions
    import op_csr_pkg::*;
#(
    parameter int PROC_COUNT = PROC_MAX
) (
    input  wire logic                    clk_in,
    input  wire logic                    nrst_in,
    input  wire op_csr_pkg::csr_req_t    csr_req_in,
    input  wire op_csr_pkg::short_read_t short_read_in,
    input  wire op_csr_pkg::csr_rsp_t    csr_rsp_out,
    input  wire op_csr_pkg::op_issue_t   op_issue_out,
    input  wire op_csr_pkg::op_issue_t   sem_issue_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    property p_load_answer;
        csr_req_in.valid && !csr_req_in.write |=> csr_rsp_out.valid;
    endproperty
    a_load_answer: assert property (p_load_answer)
        else $error("load without answer");
    property p_no_stray_answer;
        !(csr_req_in.valid && !csr_req_in.write) |=> !csr_rsp_out.valid;
    endproperty
    a_no_stray_answer: assert property (p_no_stray_answer)
        else $error("answer without load");
    property p_op_cause;
        op_issue_out.valid |-> $past(csr_req_in.valid) && $past(csr_req_in.sel) >= SEL_FETCH_INC;
    endproperty
    a_op_cause: assert property (p_op_cause)
        else $error("operation without access");
    property p_op_kind;
        op_issue_out.valid |-> 4'(op_issue_out.kind) + 4'h1 == 4'($past(csr_req_in.sel));
    endproperty
    a_op_kind: assert property (p_op_kind)
        else $error("operation kind wrong");
    property p_op_proc;
        op_issue_out.valid |-> op_issue_out.proc == $past(csr_req_in.proc);
    endproperty
    a_op_proc: assert property (p_op_proc)
        else $error("operation processor wrong");
    property p_cache_load_idle;
        csr_req_in.valid && !csr_req_in.write && csr_req_in.sel >= SEL_FLUSH
            |=> !op_issue_out.valid;
    endproperty
    a_cache_load_idle: assert property (p_cache_load_idle)
        else $error("cache load issued");
    property p_data_addr;
        op_issue_out.valid && op_issue_out.kind >= OP_COH_INC
            && $past(csr_req_in.wdata[35:34]) != 2'h0
            |-> op_issue_out.addr == $past(csr_req_in.wdata[39:0]);
    endproperty
    a_data_addr: assert property (p_data_addr)
        else $error("store data not used as address");
    property p_sem_cause;
        sem_issue_out.valid |-> $past(short_read_in.valid) && $past(short_read_in.coherent);
    endproperty
    a_sem_cause: assert property (p_sem_cause)
        else $error("semaphore without coherent read");
    property p_sem_kind;
        sem_issue_out.valid |-> sem_issue_out.proc == $past(short_read_in.proc)
            && sem_issue_out.kind inside {OP_FETCH_INC, OP_FETCH_DEC, OP_FETCH_CLR};
    endproperty
    a_sem_kind: assert property (p_sem_kind)
        else $error("semaphore kind or processor wrong");
endmodule

bind armed_trigger_operation_csrs armed_trigger_operation_csrs_assertions #(
    .PROC_COUNT(PROC_COUNT)
) chk (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .csr_req_in   (csr_req_in),
    .short_read_in(short_read_in),
    .csr_rsp_out  (csr_rsp_out),
    .op_issue_out (op_issue_out),
    .sem_issue_out(sem_issue_out)
);

// *** tb/armed_trigger_operation_csrs_tb.sv ***
// Self-checking bench for the operation CSR bank
`timescale 1ns/1ps
module armed_trigger_operation_csrs_tb;
    import op_csr_pkg::*;
    typedef struct packed {
        sel_t     sel;
        op_kind_t kind;
        logic     from_data;
    } row_t;
    logic        clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [1:0]  local_node = 2'h2;
    logic [1:0]  remap_size = 2'h0;
    csr_req_t    req;
    short_read_t sread;
    logic        tlb;
    csr_rsp_t    rsp;
    op_issue_t   op;
    op_issue_t   sem;
    op_issue_t   last_op = '0;
    logic [63:0] rd;
    logic [63:0] saved;
    logic [39:0] exp_addr;
    logic [1:0]  p;
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;
    row_t        rows [9] = '{'{SEL_FETCH_INC, OP_FETCH_INC, 1'b0},
        '{SEL_FETCH_DEC, OP_FETCH_DEC, 1'b0}, '{SEL_FETCH_CLR, OP_FETCH_CLR, 1'b0},
        '{SEL_NC_READ, OP_NC_READ, 1'b0}, '{SEL_NC_WRITE, OP_NC_WRITE, 1'b0},
        '{SEL_COH_INC, OP_COH_INC, 1'b1}, '{SEL_FLUSH, OP_FLUSH, 1'b1},
        '{SEL_PREF_RD, OP_PREF_RD, 1'b1}, '{SEL_PREF_WR, OP_PREF_WR, 1'b1}};
    logic [63:0] tlb_exp [4] = '{64'h0000_0000_0000_0003, '0, '0, 64'h0000_0000_0000_0100};
    logic [1:0]  map_size [6] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [39:0] map_in [6] = '{40'h00_0100_0040, 40'h00_0200_0040, 40'h00_0200_0040,
        40'h00_0400_0040, 40'h00_0400_0040, 40'h00_0800_0040};
    logic [39:0] map_out [6] = '{40'h08_0100_0040, 40'h00_0200_0040, 40'h08_0200_0040,
        40'h00_0400_0040, 40'h04_0400_0040, 40'h00_0800_0040};

    armed_trigger_operation_csrs #(.PROC_COUNT(4)) dut (
        .clk_in                    (clk_in),
        .nrst_in                   (nrst_in),
        .csr_req_in                (req),
        .short_read_in             (sread),
        .tlb_inval_in              (tlb),
        .local_node_in             (local_node),
        .local_remap_size_select_in(remap_size),
        .csr_rsp_out               (rsp),
        .op_issue_out              (op),
        .sem_issue_out             (sem)
    );
    proc_core_model core (
        .clk_in   (clk_in),
        .rsp_in   (rsp),
        .req_out  (req),
        .sread_out(sread),
        .tlb_out  (tlb)
    );

    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) if (op.valid) last_op <= op;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Compares %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            p = 2'(i % 4);
            core.access(1'b1, p, SEL_CONTEXT, 64'h0000_0000_0000_0001, rd);
            core.access(1'b1, p, SEL_ADDRESS, 64'h0000_0004_0000_0040, rd);
            core.access(1'b1, p, rows[i].sel, 64'h0000_0005_0000_0080, rd);
            exp_addr = rows[i].from_data ? 40'h05_0000_0080 : 40'h04_0000_0040;
            check(op.valid, 1'b1);
            check(op.kind, rows[i].kind);
            check(op.proc, p);
            check(op.addr, exp_addr);
            check(op.wdata, 64'h0000_0005_0000_0080);
            core.access(1'b0, p, SEL_CONTEXT, '0, rd);
            check(rd, 64'h0000_0000_0000_0002);
            core.access(1'b0, p, SEL_ADDRESS, '0, rd);
            check(rd, {24'h00_0000, exp_addr});
        end
        $display("Operation rows done");
        core.access(1'b1, 2'h0, SEL_CONTEXT, 64'h0000_0000_0000_0002, rd);
        core.access(1'b1, 2'h0, SEL_FLUSH, 64'h0000_0006_0000_0000, rd);
        check(op.valid, 1'b0);
        core.access(1'b0, 2'h0, SEL_CONTEXT, '0, rd);
        check(rd, 64'h0000_0000_0000_0002);
        core.access(1'b0, 2'h0, SEL_ADDRESS, '0, rd);
        check(rd, 64'h0000_0006_0000_0000);
        core.access(1'b0, 2'h0, SEL_FETCH_INC, '0, rd);
        check(op.valid, 1'b0);
        core.access(1'b0, 2'h0, SEL_CONTEXT, '0, rd);
        check(rd, '0);
        core.access(1'b1, 2'h0, SEL_CONTEXT, 64'h0000_0000_0000_0003, rd);
        core.access(1'b1, 2'h0, SEL_PREF_WR, 64'h0000_0005_0000_0100, rd);
        check(op.valid, 1'b1);
        core.access(1'b0, 2'h0, SEL_FLUSH, '0, rd);
        check(op.valid, 1'b0);
        core.access(1'b0, 2'h0, SEL_CONTEXT, '0, rd);
        check(rd, 64'h0000_0000_0000_0003);
        core.access(1'b1, 2'h1, SEL_CONTEXT, 64'h0000_0000_0000_0001, rd);
        core.access(1'b1, 2'h2, SEL_FLUSH, 64'h0000_0005_0000_0000, rd);
        check(op.valid, 1'b0);
        core.access(1'b1, 2'h3, SEL_CONTEXT, 64'h0000_0000_0000_0101, rd);
        core.tlb();
        for (int k = 0; k < 4; k++) begin
            core.access(1'b0, 2'(k), SEL_CONTEXT, '0, rd);
            check(rd, tlb_exp[k]);
        end
        $display("Flag transition tests done");
        for (int a = 0; a < 4; a++) begin
            core.access(1'b1, 2'h3, SEL_CONTEXT, 64'(a) << 8, rd);
            core.sread(2'h3, 1'b1);
            check(sem.valid, a != 0);
            if (a != 0) begin
                check(sem.kind, 64'(a));
                check(sem.proc, 2'h3);
                check(sem.addr, 40'h08_0000_1000);
            end
            core.access(1'b0, 2'h3, SEL_CONTEXT, '0, rd);
            check(rd, 64'(a != 0) << 10);
        end
        core.access(1'b1, 2'h3, SEL_CONTEXT, 64'h0000_0000_0000_0200, rd);
        core.sread(2'h3, 1'b0);
        check(sem.valid, 1'b0);
        core.access(1'b0, 2'h3, SEL_CONTEXT, '0, rd);
        check(rd, '0);
        $display("Short read tests done");
        for (int m = 0; m < 6; m++) begin
            @(posedge clk_in);
            remap_size <= map_size[m];
            local_node <= (m < 4) ? 2'h2 : 2'h1;
            core.armed_op(2'h1, SEL_FLUSH, {24'h00_0000, map_in[m]}, rd);
            check(rd[TRIG_IDX], 1'b1);
            check(last_op.addr, map_out[m]);
        end
        core.access(1'b1, 2'h0, SEL_CONTEXT, 64'h0000_0000_0000_0001, rd);
        core.abort(2'h0, saved);
        core.access(1'b0, 2'h0, SEL_CONTEXT, '0, rd);
        check(rd, '0);
        core.access(1'b1, 2'h0, SEL_CONTEXT, saved, rd);
        core.access(1'b1, 2'h0, SEL_FLUSH, 64'h0000_0005_0000_0000, rd);
        check(op.valid, 1'b1);
        $display("Remap and abort tests done");
        @(posedge clk_in);
        nrst_in <= 1'b0;
        @(posedge clk_in);
        nrst_in <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            core.access(1'b0, 2'(k), SEL_CONTEXT, '0, rd);
            check(rd, '0);
            core.access(1'b0, 2'(k), SEL_ADDRESS, '0, rd);
            check(rd, '0);
        end
        $display("Reset test done");
        give_verdict();
    end
endmodule

// *** tb/proc_core_model.sv ***
// Processor core model issuing CSR accesses, short reads and TLB invalidates
`timescale 1ns/1ps
module proc_core_model
    import op_csr_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire op_csr_pkg::csr_rsp_t  rsp_in,
    output op_csr_pkg::csr_req_t       req_out,
    output op_csr_pkg::short_read_t    sread_out,
    output logic                       tlb_out
);
    initial begin
        req_out = '0;
        sread_out = '0;
        tlb_out = 1'b0;
    end
    // One 64-bit access, result taken one cycle after the request is driven
    task automatic access(input logic w, input logic [1:0] p, input sel_t s,
                          input logic [63:0] d, output logic [63:0] rd);
        @(posedge clk_in);
        req_out <= '{1'b1, w, p, s, d};
        @(posedge clk_in);
        req_out <= '0;
        #1;
        rd = rsp_in.rdata;
    endtask
    task automatic sread(input logic [1:0] p, input logic coh);
        @(posedge clk_in);
        sread_out <= '{1'b1, p, coh, 40'h00_0000_1000};
        @(posedge clk_in);
        sread_out <= '0;
        #1;
    endtask
    task automatic tlb;
        @(posedge clk_in);
        tlb_out <= 1'b1;
        @(posedge clk_in);
        tlb_out <= 1'b0;
        #1;
    endtask
    // Arm, write address, confirm triggered, retry when not
    task automatic armed_op(input logic [1:0] p, input sel_t s, input logic [63:0] a,
                            output logic [63:0] rd);
        for (int n = 0; n < 4; n++) begin
            access(1'b1, p, SEL_CONTEXT, 64'h0000_0000_0000_0001, rd);
            access(1'b1, p, s, a, rd);
            access(1'b0, p, SEL_CONTEXT, '0, rd);
            if (rd[TRIG_IDX] === 1'b1)
                break;
        end
    endtask
    // Interrupt entry: save flags, abort a pending setup
    task automatic abort(input logic [1:0] p, output logic [63:0] saved);
        logic [63:0] junk;
        access(1'b0, p, SEL_CONTEXT, '0, saved);
        if (saved[ARMED_IDX] === 1'b1)
            access(1'b1, p, SEL_CONTEXT, '0, junk);
    endtask
endmodule
